// >>> hdl/stage2_pkg.sv
package stage2_pkg;
	// Core clock
	localparam int CLK_MHZ = 100;
	localparam int CLK_PERIOD_NS = 10;
	// Clamp overpower window and budget
	localparam int COP_WINDOW_MS = 1000;
	localparam int COP_LIMIT_US = 84480;
	localparam int COP_WINDOW_CYC = COP_WINDOW_MS * 1000 * CLK_MHZ;
	localparam int COP_LIMIT_CYC = COP_LIMIT_US * CLK_MHZ;
	// Clamp PWM period
	localparam int CLAMP_PERIOD_US = 10;
	localparam int CLAMP_PERIOD_CYC = CLAMP_PERIOD_US * CLK_MHZ;
	// Second stage timing
	localparam int MAX_ON_US = 20;
	localparam int MAX_ON_CYC = MAX_ON_US * CLK_MHZ;
	localparam int DEMAG_MAX_US = 40;
	localparam int DEMAG_MAX_CYC = DEMAG_MAX_US * CLK_MHZ;
	localparam int VALLEY_NS = 200;
	localparam int VALLEY_CYC = (VALLEY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 13;
	localparam int WIN_W = 27;
	localparam int PWM_W = 10;
	// Boost clamp limits in volts, sent to the threshold DAC
	localparam logic [8:0] CLAMP_LIM_120 = 9'h0e3;
	localparam logic [8:0] CLAMP_LIM_230 = 9'h1a8;
	// Register map
	localparam logic [7:0] ADDR_LED_ARR = 8'h23;
	localparam logic [7:0] ADDR_CH1_SP = 8'h29;
	localparam logic [7:0] ADDR_BUCK = 8'h2a;
	localparam logic [7:0] ADDR_CH2_SP = 8'h2b;
	localparam logic [7:0] ADDR_TOPO = 8'h2c;
	localparam logic [7:0] ADDR_DITHER = 8'h5d;
	localparam logic [7:0] ADDR_CTRL = 8'h70;
	localparam logic [7:0] ADDR_STATUS = 8'h71;
	localparam logic [7:0] ADDR_MASK = 8'h72;
	localparam logic [7:0] ADDR_DEMAG = 8'h73;
	localparam logic [7:0] ADDR_STATE = 8'h74;
	localparam logic [7:0] RST_CFG = 8'h00;
	// Field positions
	localparam int STRING_BIT = 0;
	localparam int LED_ARRANGEMENT_BIT_BIT = 1;
	localparam int TOPO_BIT = 0;
	localparam int DIT_NODIM_BIT = 2;
	localparam int DIT_CHAN_BIT = 3;
	localparam int DIT_ATT_LSB = 4;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_230_BIT = 1;
	localparam int ST_COP_BIT = 0;
	localparam int ST_DTO_BIT = 1;
	typedef enum logic [1:0] {TOPO_FLYBACK, TOPO_BUCK, TOPO_TAPPED} topo_t;
endpackage : stage2_pkg

// >>> hdl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // async reset
	input wire logic [W-1:0] d_i, // raw pins
	output logic [W-1:0] q_o // synchronised
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule : pin_sync

// >>> hdl/stage2_ctrl.sv
// Behaviour
// - Clamp transistor PWM loop holds boost voltage below 227V or 424V.
// - Over 84.48ms clamp on-time per second trips fault, stops both stages.
// - Clamp drive is held off while the overpower fault stands.
// - Topology bit and buck field choose flyback, buck or tapped buck.
// - String bit and LED arrangement bit set series or parallel output.
// - Each channel has its own peak-current loop giving its peak limit.
// - Sequencer picks each event's active channel and tracks the phase.
// - Gate turns off when sensed current reaches the active channel limit.
// - Demagnetization interval is measured from zero-current detect input.
// - Each cycle starts only after demagnetization has finished, except a start from idle (enable or demag timeout).
// - Channel target comes from its setpoint, 511 equals full-scale sense.
// - Dim to current mapping is monotonic from 0% to 100%, with a step at dim 128 where the setpoint is added once more.
// - Two-bit dither level field sets the frequency dither amount.
// - With no-dimmer dither bit set, dither only in no-dimmer mode.
// - Channel opposite the channel bit's value gets dither reduced by the two-bit attenuation field.
`timescale 1ns/10ps
module stage2_ctrl
	import stage2_pkg::*;
#(
	parameter int WINDOW_CYC = COP_WINDOW_CYC,
	parameter int LIMIT_CYC = COP_LIMIT_CYC
) (
	input wire logic mclk_i, // core clock
	input wire logic rst_i, // async reset
	input wire logic [7:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after rd_i
	input wire logic [7:0] dim_i, // dim level, 255 full
	input wire logic no_dimmer_i, // no-dimmer mode active
	input wire logic [8:0] isense_i, // inductor current code
	input wire logic zcd_i, // aux winding demag comparator pin
	input wire logic vbst_high_i, // boost above clamp limit pin
	output logic gate_o, // gate drive
	output logic active_chan_o, // channel of this cycle
	output logic chan_pmos_o, // channel switch is PMOS type
	output logic parallel_o, // parallel arrangement
	output logic string_o, // string arrangement bit
	output logic [1:0] topology_o, // topology code
	output logic clamp_o, // clamp transistor drive
	output logic [8:0] clamp_limit_o, // clamp threshold in volts
	output logic boost_en_o, // boost stage enable
	output logic cop_fault_o, // clamp overpower fault
	output logic irq_o // interrupt, level
);
	import stage2_pkg::*;

	typedef enum {ST_IDLE, ST_ON, ST_DEMAG, ST_DELAY} seq_t;

	logic [1:0] pin_s;
	logic zcd_s, vbst_s;
	logic [7:0] arr_q, sp1_q, buck_q, sp2_q, topo_q, dith_q, ctrl_q, mask_q;
	logic [1:0] status_q, evt_d;
	seq_t state_q;
	logic [CNT_W-1:0] cnt_q, t2_q;
	logic chan_q, zcd_seen_q, demag_ok_q, dto_evt;
	logic [8:0] peak_q [2];
	logic [8:0] target [2];
	logic [17:0] prod [2];
	logic [8:0] peak_sel;
	logic [7:0] lfsr_q, dith_raw, dith_amt, dith_cut;
	logic dith_en;
	logic [PWM_W-1:0] pwm_cnt_q, duty_q;
	logic [WIN_W-1:0] win_cnt_q, acc_q;
	logic cop_q, cop_evt, run;
	topo_t topo_d;
	logic [7:0] rd_mux;

	pin_sync #(.W(2)) u_sync (
		.clk_i(mclk_i),
		.rst_i(rst_i),
		.d_i({zcd_i, vbst_high_i}),
		.q_o(pin_s)
	);
	assign zcd_s = pin_s[1];
	assign vbst_s = pin_s[0];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			arr_q <= RST_CFG;
			sp1_q <= RST_CFG;
			buck_q <= RST_CFG;
			sp2_q <= RST_CFG;
			topo_q <= RST_CFG;
			dith_q <= RST_CFG;
			ctrl_q <= RST_CFG;
			mask_q <= RST_CFG;
		end else if (wr_i) begin
			case (addr_i)
				ADDR_LED_ARR: arr_q <= wdata_i;
				ADDR_CH1_SP: sp1_q <= wdata_i;
				ADDR_BUCK: buck_q <= wdata_i;
				ADDR_CH2_SP: sp2_q <= wdata_i;
				ADDR_TOPO: topo_q <= wdata_i;
				ADDR_DITHER: dith_q <= wdata_i;
				ADDR_CTRL: ctrl_q <= wdata_i;
				ADDR_MASK: mask_q <= wdata_i;
				default: ;
			endcase
		end
	end

	// Hardware set beats a same-cycle write-one-to-clear
	assign evt_d = {dto_evt, cop_evt};
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			status_q <= '0;
		end else if (wr_i && addr_i == ADDR_STATUS) begin
			status_q <= (status_q & ~wdata_i[1:0]) | evt_d;
		end else begin
			status_q <= status_q | evt_d;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((status_q | evt_d) & mask_q[1:0]);
		end
	end

	always_comb begin
		case (addr_i)
			ADDR_LED_ARR: rd_mux = arr_q;
			ADDR_CH1_SP: rd_mux = sp1_q;
			ADDR_BUCK: rd_mux = buck_q;
			ADDR_CH2_SP: rd_mux = sp2_q;
			ADDR_TOPO: rd_mux = topo_q;
			ADDR_DITHER: rd_mux = dith_q;
			ADDR_CTRL: rd_mux = ctrl_q;
			ADDR_STATUS: rd_mux = {6'h00, status_q};
			ADDR_MASK: rd_mux = mask_q;
			ADDR_DEMAG: rd_mux = t2_q[CNT_W-1:CNT_W-8];
			ADDR_STATE: rd_mux = {4'h0, dith_en, cop_q, chan_q, gate_o};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? rd_mux : 8'h00;
		end
	end

	// Topology and arrangement decode
	always_comb begin
		if (!topo_q[TOPO_BIT]) begin
			topo_d = TOPO_FLYBACK;
		end else if (buck_q[3:0] == 4'h0) begin
			topo_d = TOPO_BUCK;
		end else begin
			topo_d = TOPO_TAPPED;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			topology_o <= 2'h0;
			chan_pmos_o <= 1'b0;
			parallel_o <= 1'b0;
			string_o <= 1'b0;
		end else begin
			topology_o <= topo_d;
			chan_pmos_o <= topo_d != TOPO_FLYBACK;
			parallel_o <= arr_q[LED_ARRANGEMENT_BIT_BIT];
			string_o <= arr_q[STRING_BIT];
		end
	end

	// Target current: setpoint widened so 255 reaches 511, scaled by dim
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			prod[c] = {(c == 0) ? {sp1_q, sp1_q[7]} : {sp2_q, sp2_q[7]}}
				* {9'h000, 1'b0, dim_i} + {9'h000, 9'h000};
			if (dim_i[7]) begin
				prod[c] = prod[c] + {9'h000,
					(c == 0) ? {sp1_q, sp1_q[7]} : {sp2_q, sp2_q[7]}};
			end
			target[c] = prod[c][16:8];
		end
	end

	// Per channel loop steps the peak limit toward its target once a cycle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			peak_q[0] <= 9'h000;
			peak_q[1] <= 9'h000;
		end else if (state_q == ST_ON && !gate_o) begin
			if (peak_q[chan_q] < target[chan_q]) begin
				peak_q[chan_q] <= peak_q[chan_q] + 9'h001;
			end else if (peak_q[chan_q] > target[chan_q]) begin
				peak_q[chan_q] <= peak_q[chan_q] - 9'h001;
			end
		end
	end
	assign peak_sel = peak_q[chan_q];

	// Dither amount: level widens the random span, one channel attenuated
	always_comb begin
		dith_en = dith_q[1:0] != 2'h0 &&
			(!dith_q[DIT_NODIM_BIT] || no_dimmer_i);
		dith_raw = lfsr_q >> (2'h3 - dith_q[1:0]);
		dith_cut = 8'((dith_raw >> 2) * dith_q[DIT_ATT_LSB +: 2]);
		if (!dith_en) begin
			dith_amt = 8'h00;
		end else if (dith_q[DIT_CHAN_BIT] == ~chan_q) begin
			dith_amt = dith_raw - dith_cut;
		end else begin
			dith_amt = dith_raw;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			lfsr_q <= 8'h01;
		end else if (state_q == ST_DELAY && cnt_q == '0) begin
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		end
	end

	assign run = ctrl_q[CTRL_EN_BIT] && !cop_q;

	// Switching sequencer; gate and channel change on the same edge
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			t2_q <= '0;
			gate_o <= 1'b0;
			chan_q <= 1'b0;
			zcd_seen_q <= 1'b0;
			demag_ok_q <= 1'b0;
			dto_evt <= 1'b0;
		end else begin
			dto_evt <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					if (run) begin
						state_q <= ST_ON;
						gate_o <= 1'b1;
						cnt_q <= '0;
					end
				end
				ST_ON: begin
					cnt_q <= cnt_q + 1'b1;
					if (!run) begin
						state_q <= ST_IDLE;
						gate_o <= 1'b0;
					end else if (!gate_o) begin
						state_q <= ST_DEMAG;
						cnt_q <= '0;
						zcd_seen_q <= 1'b0;
					end else if (isense_i >= peak_sel ||
						cnt_q == CNT_W'(MAX_ON_CYC - 1)) begin
						gate_o <= 1'b0;
					end
				end
				ST_DEMAG: begin
					cnt_q <= cnt_q + 1'b1;
					if (zcd_s) begin
						zcd_seen_q <= 1'b1;
					end
					if (!run) begin
						state_q <= ST_IDLE;
					end else if (zcd_seen_q && !zcd_s) begin
						t2_q <= cnt_q;
						demag_ok_q <= 1'b1;
						state_q <= ST_DELAY;
						cnt_q <= CNT_W'(VALLEY_CYC) + CNT_W'(dith_amt);
					end else if (cnt_q == CNT_W'(DEMAG_MAX_CYC - 1)) begin
						dto_evt <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_DELAY: begin
					cnt_q <= cnt_q - 1'b1;
					if (!run) begin
						state_q <= ST_IDLE;
						demag_ok_q <= 1'b0;
					end else if (cnt_q == '0) begin
						state_q <= ST_ON;
						gate_o <= 1'b1;
						chan_q <= ~chan_q;
						demag_ok_q <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			active_chan_o <= 1'b0;
		end else begin
			active_chan_o <= chan_q;
		end
	end

	// Clamp PWM: duty creeps up while boost is over limit, down otherwise
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_cnt_q <= '0;
			duty_q <= '0;
		end else if (pwm_cnt_q == PWM_W'(CLAMP_PERIOD_CYC - 1)) begin
			pwm_cnt_q <= '0;
			if (vbst_s && duty_q != PWM_W'(CLAMP_PERIOD_CYC)) begin
				duty_q <= duty_q + 1'b1;
			end else if (!vbst_s && duty_q != '0) begin
				duty_q <= duty_q - 1'b1;
			end
		end else begin
			pwm_cnt_q <= pwm_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			clamp_o <= 1'b0;
			clamp_limit_o <= CLAMP_LIM_120;
		end else begin
			clamp_o <= !cop_q && !cop_evt && pwm_cnt_q < duty_q;
			clamp_limit_o <= ctrl_q[CTRL_230_BIT] ? CLAMP_LIM_230
				: CLAMP_LIM_120;
		end
	end

	// Overpower window; fault stays until reset, power cycle in the system
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			win_cnt_q <= '0;
			acc_q <= '0;
		end else if (win_cnt_q == WIN_W'(WINDOW_CYC - 1)) begin
			win_cnt_q <= '0;
			acc_q <= '0;
		end else begin
			win_cnt_q <= win_cnt_q + 1'b1;
			acc_q <= acc_q + WIN_W'(clamp_o);
		end
	end

	assign cop_evt = !cop_q && acc_q > WIN_W'(LIMIT_CYC);
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cop_q <= 1'b0;
		end else if (cop_evt) begin
			cop_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			boost_en_o <= 1'b0;
			cop_fault_o <= 1'b0;
		end else begin
			boost_en_o <= ctrl_q[CTRL_EN_BIT] && !cop_q && !cop_evt;
			cop_fault_o <= cop_q;
		end
	end

	// Helper: channel served by the previous gate start
	logic last_chan_q, started_q;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			last_chan_q <= 1'b0;
			started_q <= 1'b0;
		end else begin
			started_q <= gate_o;
			if (gate_o && !started_q) begin
				last_chan_q <= chan_q;
			end
		end
	end

	clamp_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cop_q |=> !clamp_o)
		else $error("clamp driven during overpower fault");
	cop_trip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cop_evt |=> cop_q ##1 (cop_fault_o && !boost_en_o && !gate_o))
		else $error("overpower did not stop the stages");
	window_clear_a: assert property (@(posedge mclk_i)
		disable iff (rst_i)
		win_cnt_q == WIN_W'(WINDOW_CYC - 1) |=> acc_q == '0)
		else $error("on-time carried into next window");
	gate_peak_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		state_q == ST_ON && gate_o && run && isense_i >= peak_sel
		|=> !gate_o)
		else $error("gate not cut at peak limit");
	qr_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(gate_o) |-> $past(state_q) == ST_IDLE || $past(demag_ok_q))
		else $error("cycle started before demagnetization end");
	chan_alt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(gate_o) && $past(state_q) == ST_DELAY
		|-> chan_q != last_chan_q ##1 active_chan_o == chan_q)
		else $error("channel did not alternate");
	topo_map_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		##1 topology_o == (!$past(topo_q[TOPO_BIT]) ? 2'(TOPO_FLYBACK) :
		($past(buck_q[3:0]) == 4'h0 ? 2'(TOPO_BUCK) : 2'(TOPO_TAPPED))))
		else $error("topology decode wrong");
	dither_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		dith_q[DIT_NODIM_BIT] && !no_dimmer_i |-> dith_amt == 8'h00)
		else $error("dither outside no-dimmer mode");
	dim_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		dim_i == 8'h00 |-> target[0] == 9'h000 && target[1] == 9'h000)
		else $error("zero dim gives nonzero target");
	irq_level_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		|(status_q & mask_q[1:0]) |=> irq_o)
		else $error("interrupt not raised");
endmodule : stage2_ctrl

// >>> tb/power_stage_model.sv
`timescale 1ns/10ps
module power_stage_model #(
	parameter int DEMAG_CYC = 64
) (
	input wire logic mclk_i, // core clock
	input wire logic rst_i, // async reset
	input wire logic gate_i, // gate drive from the controller
	input wire logic stuck_i, // hold the demag comparator high
	output logic [8:0] isense_o, // inductor current code
	output logic zcd_o, // high while demagnetizing
	output logic chan_o // channel lit by the secondary toggle
);
	logic gate_q;
	logic [7:0] demag_q;
	// Switch open means no current through the sense resistor
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			isense_o <= 9'h000;
		end else if (!gate_i) begin
			isense_o <= 9'h000;
		end else if (isense_o != 9'h1ff) begin
			isense_o <= isense_o + 9'h001;
		end
	end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			gate_q <= 1'b0;
			demag_q <= 8'h00;
		end else begin
			gate_q <= gate_i;
			if (gate_q && !gate_i) begin
				demag_q <= 8'(DEMAG_CYC);
			end else if (demag_q != 8'h00) begin
				demag_q <= demag_q - 8'h01;
			end
		end
	end
	assign zcd_o = stuck_i | (demag_q != 8'h00);
	// Toggle flips to the other string on every switching event
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// Parked on the second string so the first event lights the first
			chan_o <= 1'b1;
		end else if (gate_i && !gate_q) begin
			chan_o <= ~chan_o;
		end
	end
endmodule : power_stage_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
	import stage2_pkg::*;
	localparam int WIN = 20000;
	localparam int LIM = 300;
	localparam int CEIL = 95000;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] dim_i = 8'hff;
	logic no_dimmer_i = 1'b0;
	logic vbst_high_i = 1'b0;
	logic stuck = 1'b0;
	logic [7:0] rdata_o;
	logic [8:0] isense;
	logic zero_current_detect, gate_o, active_chan_o, chan_pmos_o, parallel_o, string_o;
	logic [1:0] topology_o;
	logic clamp_o, boost_en_o, cop_fault_o, irq_o, toggle_chan;
	logic [8:0] clamp_limit_o;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int zlow = 0;

	stage2_ctrl #(.WINDOW_CYC(WIN), .LIMIT_CYC(LIM)) i_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dim_i(dim_i),
		.no_dimmer_i(no_dimmer_i), .isense_i(isense), .zcd_i(zero_current_detect),
		.vbst_high_i(vbst_high_i), .gate_o(gate_o),
		.active_chan_o(active_chan_o), .chan_pmos_o(chan_pmos_o),
		.parallel_o(parallel_o), .string_o(string_o),
		.topology_o(topology_o), .clamp_o(clamp_o),
		.clamp_limit_o(clamp_limit_o), .boost_en_o(boost_en_o),
		.cop_fault_o(cop_fault_o), .irq_o(irq_o));
	power_stage_model i_psm (.mclk_i(mclk_i), .rst_i(rst_i),
		.gate_i(gate_o), .stuck_i(stuck), .isense_o(isense), .zcd_o(zero_current_detect),
		.chan_o(toggle_chan));

	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		zlow = zero_current_detect ? 0 : zlow + 1;
		if (cycles == CEIL) begin
			miscompares++;
			report_and_stop();
		end
	end

	task report_and_stop();
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task chk(input logic [8:0] exp, input logic [8:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t exp %h got %h", $time, exp, got);
		end
	endtask : chk
	task chk_in(input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("ERROR %0t exp %h..%h got %h", $time, lo, hi, got);
		end
	endtask : chk_in
	task tick();
		@(posedge mclk_i);
		#1;
	endtask : tick
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	// One switching event: on-time length and the channel it served
	task cyc(output int len, output logic ch);
		int n;
		n = 0;
		while (gate_o === 1'b1 && n < 3000) begin tick(); n++; end
		while (gate_o !== 1'b1 && n < 9000) begin tick(); n++; end
		chk_in(20, 8999, zlow);
		len = 0;
		ch = 1'bx;
		while (gate_o === 1'b1 && len < 2100) begin
			tick();
			len++;
			if (len == 2) ch = active_chan_o;
		end
	endtask : cyc

	task regs_test();
		logic [7:0] a [6];
		logic [7:0] d;
		a = '{ADDR_LED_ARR, ADDR_CH1_SP, ADDR_BUCK, ADDR_CH2_SP, ADDR_TOPO,
			ADDR_DITHER};
		foreach (a[i]) begin
			rd(a[i], d);
			chk(9'h000, {1'b0, d});
			wr(a[i], 8'ha5 ^ 8'(i));
			rd(a[i], d);
			chk({1'b0, 8'ha5 ^ 8'(i)}, {1'b0, d});
		end
		rd(8'h00, d);
		chk(9'h000, {1'b0, d});
		wr(ADDR_LED_ARR, 8'h02);
		repeat (3) tick();
		chk(9'h002, {7'h00, parallel_o, string_o});
		wr(ADDR_TOPO, 8'h00);
		repeat (3) tick();
		chk({7'h00, TOPO_FLYBACK}, {7'h00, topology_o});
		chk(9'h000, {8'h00, chan_pmos_o});
		wr(ADDR_TOPO, 8'h01);
		wr(ADDR_BUCK, 8'h00);
		repeat (3) tick();
		chk({7'h00, TOPO_BUCK}, {7'h00, topology_o});
		chk(9'h001, {8'h00, chan_pmos_o});
		wr(ADDR_BUCK, 8'h05);
		repeat (3) tick();
		chk({7'h00, TOPO_TAPPED}, {7'h00, topology_o});
	endtask : regs_test

	task dither_test();
		logic [7:0] d;
		wr(ADDR_DITHER, 8'h37);
		no_dimmer_i <= 1'b0;
		rd(ADDR_STATE, d);
		chk(9'h000, {8'h00, d[3]});
		no_dimmer_i <= 1'b1;
		repeat (3) tick();
		rd(ADDR_STATE, d);
		chk(9'h001, {8'h00, d[3]});
	endtask : dither_test

	task switch_test();
		int len;
		logic ch, prev;
		logic [7:0] d;
		wr(ADDR_CH1_SP, 8'h20);
		wr(ADDR_CH2_SP, 8'h10);
		// Lowest dither level keeps the long warm-up inside the run budget
		wr(ADDR_DITHER, 8'h35);
		wr(ADDR_CTRL, 8'h01);
		repeat (3) tick();
		chk(9'h001, {8'h00, boost_en_o});
		// Limits climb one code per own cycle, so give both loops time
		repeat (140) cyc(len, prev);
		for (int i = 0; i < 4; i++) begin
			cyc(len, ch);
			chk({8'h00, ~prev}, {8'h00, ch});
			chk({8'h00, ch}, {8'h00, toggle_chan});
			if (ch === 1'b0) chk_in(60, 72, len);
			else chk_in(28, 40, len);
			prev = ch;
		end
		rd(ADDR_DEMAG, d);
		chk(9'h002, {1'b0, d});
		dim_i <= 8'h80;
		repeat (80) cyc(len, ch);
		cyc(len, ch);
		if (ch !== 1'b0) cyc(len, ch);
		chk_in(28, 40, len);
		chk(9'h000, {8'h00, ch});
		dim_i <= 8'h00;
		repeat (2) tick();
		dim_i <= 8'h80;
	endtask : switch_test

	task timeout_test();
		logic [7:0] d;
		wr(ADDR_MASK, 8'h00);
		stuck <= 1'b1;
		repeat (4200) tick();
		rd(ADDR_STATUS, d);
		chk(9'h002, {1'b0, d & 8'h02});
		chk(9'h000, {8'h00, irq_o});
		wr(ADDR_MASK, 8'h02);
		repeat (3) tick();
		chk(9'h001, {8'h00, irq_o});
		stuck <= 1'b0;
		wr(ADDR_STATUS, 8'h02);
		rd(ADDR_STATUS, d);
		chk(9'h000, {1'b0, d});
		tick();
		chk(9'h000, {8'h00, irq_o});
	endtask : timeout_test

	task clamp_test();
		int n;
		int bad;
		logic [7:0] d;
		chk(9'h0e3, clamp_limit_o);
		wr(ADDR_CTRL, 8'h03);
		repeat (3) tick();
		chk(9'h1a8, clamp_limit_o);
		vbst_high_i <= 1'b1;
		n = 0;
		while (clamp_o !== 1'b1 && n < 3000) begin tick(); n++; end
		chk(9'h001, {8'h00, clamp_o});
		n = 0;
		while (cop_fault_o !== 1'b1 && n < 60000) begin tick(); n++; end
		chk(9'h001, {8'h00, cop_fault_o});
		wr(ADDR_MASK, 8'h01);
		bad = 0;
		repeat (2000) begin
			tick();
			if (clamp_o !== 1'b0) bad++;
			if (gate_o !== 1'b0 || boost_en_o !== 1'b0) bad++;
		end
		chk_in(0, 0, bad);
		chk(9'h001, {8'h00, irq_o});
		wr(ADDR_STATUS, 8'h01);
		rd(ADDR_STATUS, d);
		chk(9'h000, {1'b0, d & 8'h01});
		chk(9'h001, {8'h00, cop_fault_o});
	endtask : clamp_test

	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		regs_test();
		dither_test();
		switch_test();
		timeout_test();
		clamp_test();
		report_and_stop();
	end
endmodule : tb
